// ### verilog/fssc_bank.sv
/*
 * Register bank for fan output disables, module presence, processor
 * configuration, over-temperature status and per-fan source enables.
 * Assumes an Avalon-MM master on clk; status inputs are synchronous.
 */
// Overview of operation
// - Config bits 0-2 disable fan outputs.
// - Presence bits 4-7 gate module forwarding.
// - Bits 3-5 select dual domain per CPU.
// - Bits 7:6 give processor count minus one.
// - Status bits 0-3 flag processor overtemp.
// - Status bits 4-6 flag shutdown limits.
// - Status bit 7 summarises external status.
// - Fan1 sensor enables in bits 0-6.
// - Fan1 sensor enable resets to 0x08.
// - Fan1 bus device enables bits 0-7.
// - Fan1 pushed value enables bits 0-3.
// - Fan2 sensor enables, reset zero.
// - Fan2 bus device enables bits 0-2.
`timescale 1ns/1ps
module fssc_bank (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic      [1:0]  avs_response,
    // Temperature inputs
    input  wire logic [55:0] sensor_temps,
    input  wire logic [63:0] bus_dev_temps,
    input  wire logic [31:0] written_temps,
    // Condition inputs
    input  wire logic [3:0]  proc_ctrl_temp_over,
    input  wire logic        remote_a_over_limit,
    input  wire logic        local_over_limit,
    input  wire logic        remote_b_over_limit,
    input  wire logic        ext_status_any,
    input  wire logic [3:0]  module_temp_valid,
    // Configuration outputs
    output logic      [2:0]  fan_out_disable,
    output logic      [3:0]  module_forward_en,
    output logic      [2:0]  cpu_dual_domain,
    output logic      [2:0]  cpu_count,
    output logic      [7:0]  supply_rail_high_limit,
    output logic      [7:0]  fan1_demand,
    output logic             fan1_active,
    output logic      [7:0]  fan2_demand,
    output logic             fan2_active
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {IDLE, ANSWER, DONE} fssc_bus_state_type;

    typedef struct packed {
        fssc_bus_state_type    bus;
        logic                  wreq;
        logic [31:0]           rdata;
        logic [1:0]            resp;
        fssc_pkg::fssc_byte_type rail_hi;
        fssc_pkg::fssc_byte_type cfg9;
        fssc_pkg::fssc_byte_type cpu_cfg;
        fssc_pkg::fssc_byte_type status;
        fssc_pkg::fssc_byte_type p1_sensor;
        fssc_pkg::fssc_byte_type p1_busdev;
        fssc_pkg::fssc_byte_type p1_pushed;
        fssc_pkg::fssc_byte_type p2_sensor;
        fssc_pkg::fssc_byte_type p2_busdev;
        logic [3:0]            fwd;
        logic [2:0]            count;
        logic [7:0]            f1_dem;
        logic                  f1_on;
        logic [7:0]            f2_dem;
        logic                  f2_on;
    } fssc_state_type;

    fssc_state_type st_r;
    fssc_state_type st_nxt;

    fssc_sel_if sel1 ();
    fssc_sel_if sel2 ();

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Byte-enable lane 0 gates every write, so a write with lane 0 off is
    // accepted but changes nothing.
    function automatic fssc_pkg::fssc_byte_type wr_field(
        input fssc_pkg::fssc_byte_type old_v,
        input fssc_pkg::fssc_byte_type new_v,
        input fssc_pkg::fssc_byte_type mask
    );
        wr_field = (old_v & ~mask) | (new_v & mask);
    endfunction

    function automatic logic hit(
        input logic [9:0] addr,
        input logic [7:0] idx
    );
        hit = (addr[9:2] == idx) && (addr[1:0] == 2'b00);
    endfunction

    // ------------------------------------------------------------------
    // Source selection for both fan outputs
    // ------------------------------------------------------------------
    // A disabled fan output sees no sources, so its demand drops to zero.
    assign sel1.enable = st_r.cfg9[fssc_pkg::CFG9_FAN_OFF_LSB] ? '0 :
                         {st_r.p1_pushed[3:0], st_r.p1_busdev,
                          st_r.p1_sensor[6:0]};
    assign sel2.enable = st_r.cfg9[fssc_pkg::CFG9_FAN_OFF_LSB + 1] ? '0 :
                         {4'h0, 5'h00, st_r.p2_busdev[2:0],
                          st_r.p2_sensor[6:0]};
    assign sel1.temps  = {written_temps, bus_dev_temps, sensor_temps};
    assign sel2.temps  = {written_temps, bus_dev_temps, sensor_temps};

    fssc_src_select u_sel1 (
        .clk (clk),
        .rst (rst),
        .s   (sel1.sel)
    );

    fssc_src_select u_sel2 (
        .clk (clk),
        .rst (rst),
        .s   (sel2.sel)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [7:0] rv;
        rv = 8'h00;
        st_nxt = st_r;
        // Status mirrors live conditions; host writes never touch it.
        st_nxt.status[fssc_pkg::ST_PROC_LSB +: 4] = proc_ctrl_temp_over;
        st_nxt.status[fssc_pkg::ST_REMOTE_A] = remote_a_over_limit;
        st_nxt.status[fssc_pkg::ST_LOCAL]    = local_over_limit;
        st_nxt.status[fssc_pkg::ST_REMOTE_B] = remote_b_over_limit;
        st_nxt.status[fssc_pkg::ST_SUMMARY]  = ext_status_any;
        st_nxt.fwd = module_temp_valid &
                     st_r.cfg9[fssc_pkg::CFG9_PRESENT_LSB +: 4];
        st_nxt.count = {1'b0, st_r.cpu_cfg[fssc_pkg::CPU_COUNT_LSB +: 2]}
                       + 3'd1;
        st_nxt.f1_dem = sel1.demand;
        st_nxt.f1_on  = sel1.any_on;
        st_nxt.f2_dem = sel2.demand;
        st_nxt.f2_on  = sel2.any_on;

        unique case (st_r.bus)
            IDLE: begin
                if (avs_read || avs_write) begin
                    st_nxt.bus = ANSWER;
                end
            end
            ANSWER: begin
                st_nxt.bus  = DONE;
                st_nxt.resp = 2'b00;
                if (hit(avs_address, fssc_pkg::IDX_RAIL_HI)) begin
                    rv = st_r.rail_hi;
                end else if (hit(avs_address, fssc_pkg::IDX_CFG9)) begin
                    rv = st_r.cfg9;
                end else if (hit(avs_address, fssc_pkg::IDX_CPU_CFG)) begin
                    rv = st_r.cpu_cfg;
                end else if (hit(avs_address, fssc_pkg::IDX_OT_STATUS)) begin
                    rv = st_r.status;
                end else if (hit(avs_address, fssc_pkg::IDX_P1_SENSOR)) begin
                    rv = st_r.p1_sensor;
                end else if (hit(avs_address, fssc_pkg::IDX_P1_BUSDEV)) begin
                    rv = st_r.p1_busdev;
                end else if (hit(avs_address, fssc_pkg::IDX_P1_PUSHED)) begin
                    rv = st_r.p1_pushed;
                end else if (hit(avs_address, fssc_pkg::IDX_P2_SENSOR)) begin
                    rv = st_r.p2_sensor;
                end else if (hit(avs_address, fssc_pkg::IDX_P2_BUSDEV)) begin
                    rv = st_r.p2_busdev;
                end else begin
                    st_nxt.resp = 2'b10;
                end
                st_nxt.rdata = avs_read ? {24'h000000, rv} : 32'h00000000;
                if (avs_write && avs_byteenable[0]) begin
                    if (hit(avs_address, fssc_pkg::IDX_RAIL_HI)) begin
                        st_nxt.rail_hi = wr_field(st_r.rail_hi, avs_writedata[7:0],
                                                  fssc_pkg::WM_FULL);
                    end
                    if (hit(avs_address, fssc_pkg::IDX_CFG9)) begin
                        st_nxt.cfg9 = wr_field(st_r.cfg9, avs_writedata[7:0],
                                               fssc_pkg::WM_CFG9);
                    end
                    if (hit(avs_address, fssc_pkg::IDX_CPU_CFG)) begin
                        st_nxt.cpu_cfg = wr_field(st_r.cpu_cfg, avs_writedata[7:0],
                                                  fssc_pkg::WM_CPU_CFG);
                    end
                    if (hit(avs_address, fssc_pkg::IDX_P1_SENSOR)) begin
                        st_nxt.p1_sensor = wr_field(st_r.p1_sensor, avs_writedata[7:0],
                                                    fssc_pkg::WM_SENSOR);
                    end
                    if (hit(avs_address, fssc_pkg::IDX_P1_BUSDEV)) begin
                        st_nxt.p1_busdev = wr_field(st_r.p1_busdev, avs_writedata[7:0],
                                                    fssc_pkg::WM_FULL);
                    end
                    if (hit(avs_address, fssc_pkg::IDX_P1_PUSHED)) begin
                        st_nxt.p1_pushed = wr_field(st_r.p1_pushed, avs_writedata[7:0],
                                                    fssc_pkg::WM_PUSHED);
                    end
                    if (hit(avs_address, fssc_pkg::IDX_P2_SENSOR)) begin
                        st_nxt.p2_sensor = wr_field(st_r.p2_sensor, avs_writedata[7:0],
                                                    fssc_pkg::WM_SENSOR);
                    end
                    if (hit(avs_address, fssc_pkg::IDX_P2_BUSDEV)) begin
                        st_nxt.p2_busdev = wr_field(st_r.p2_busdev, avs_writedata[7:0],
                                                    fssc_pkg::WM_P2_BUSDEV);
                    end
                end
            end
            DONE: begin
                st_nxt.bus = IDLE;
            end
            default: begin
                st_nxt.bus = IDLE;
            end
        endcase
        st_nxt.wreq = (st_nxt.bus != DONE);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r           <= '0;
            st_r.bus       <= IDLE;
            st_r.wreq      <= 1'b1;
            st_r.rail_hi   <= fssc_pkg::RST_RAIL_HI;
            st_r.cfg9      <= fssc_pkg::RST_CFG9;
            st_r.cpu_cfg   <= fssc_pkg::RST_CPU_CFG;
            st_r.p1_sensor <= fssc_pkg::RST_P1_SENSOR;
            st_r.p2_sensor <= fssc_pkg::RST_ZERO;
            st_r.count     <= 3'd1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Waitrequest has its own flop and is low only in the DONE cycle; read
    // data and response load at the same edge, so the master sees them settled.
    assign avs_waitrequest        = st_r.wreq;
    assign avs_readdata           = st_r.rdata;
    assign avs_response           = st_r.resp;
    assign fan_out_disable        = st_r.cfg9[fssc_pkg::CFG9_FAN_OFF_LSB +: 3];
    assign module_forward_en      = st_r.fwd;
    assign cpu_dual_domain        = {st_r.cpu_cfg[fssc_pkg::CPU_DOMAIN_LSB],
                                     st_r.cpu_cfg[fssc_pkg::CPU_DOMAIN_LSB + 1],
                                     st_r.cpu_cfg[fssc_pkg::CPU_DOMAIN_LSB + 2]};
    assign cpu_count              = st_r.count;
    assign supply_rail_high_limit = st_r.rail_hi;
    assign fan1_demand            = st_r.f1_dem;
    assign fan1_active            = st_r.f1_on;
    assign fan2_demand            = st_r.f2_dem;
    assign fan2_active            = st_r.f2_on;
endmodule // fssc_bank

// ### verilog/fssc_pkg.sv
/*
 * Package of the fan source select register bank: register offsets, bit
 * positions, reset values and the Avalon-MM geometry.
 * Assumes byte-wide registers, one per aligned 32-bit word.
 */
package fssc_pkg;
    // Register indices as printed; byte address is four times the index.
    localparam logic [7:0] IDX_RAIL_HI    = 8'h86;
    localparam logic [7:0] IDX_CFG9       = 8'h87;
    localparam logic [7:0] IDX_CPU_CFG    = 8'h88;
    localparam logic [7:0] IDX_OT_STATUS  = 8'h89;
    localparam logic [7:0] IDX_P1_SENSOR  = 8'h8a;
    localparam logic [7:0] IDX_P1_BUSDEV  = 8'h8b;
    localparam logic [7:0] IDX_P1_PUSHED  = 8'h8c;
    localparam logic [7:0] IDX_P2_SENSOR  = 8'h8d;
    localparam logic [7:0] IDX_P2_BUSDEV  = 8'h8e;
    localparam int         NUM_REGS       = 9;
    localparam int         ADDR_W         = 10;

    // Reset values.
    localparam logic [7:0] RST_RAIL_HI    = 8'hff;
    localparam logic [7:0] RST_CFG9       = 8'h00;
    localparam logic [7:0] RST_CPU_CFG    = 8'h00;
    localparam logic [7:0] RST_P1_SENSOR  = 8'h08;
    localparam logic [7:0] RST_ZERO       = 8'h00;

    // Writable bit masks; reserved bits stay zero.
    localparam logic [7:0] WM_CFG9        = 8'hf7;
    localparam logic [7:0] WM_CPU_CFG     = 8'hf8;
    localparam logic [7:0] WM_SENSOR      = 8'h7f;
    localparam logic [7:0] WM_PUSHED      = 8'h0f;
    localparam logic [7:0] WM_P2_BUSDEV   = 8'h07;
    localparam logic [7:0] WM_FULL        = 8'hff;

    // Field positions.
    localparam int CFG9_FAN_OFF_LSB  = 0;
    localparam int CFG9_PRESENT_LSB  = 4;
    localparam int CPU_DOMAIN_LSB    = 3;
    localparam int CPU_COUNT_LSB     = 6;
    localparam int ST_PROC_LSB       = 0;
    localparam int ST_REMOTE_A       = 4;
    localparam int ST_LOCAL          = 5;
    localparam int ST_REMOTE_B       = 6;
    localparam int ST_SUMMARY        = 7;

    // Source vector layout for the highest-demand selector.
    localparam int NUM_SRC           = 19;
    localparam int SRC_SENSOR_LSB    = 0;
    localparam int SRC_BUSDEV_LSB    = 7;
    localparam int SRC_PUSHED_LSB    = 15;

    typedef logic [7:0] fssc_byte_type;
endpackage

// ### verilog/fssc_sel_if.sv
/*
 * Interface carrying enable masks, temperatures and the chosen demand
 * between the register bank and its source selector.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
interface fssc_sel_if;
    logic [fssc_pkg::NUM_SRC-1:0] enable;
    logic [fssc_pkg::NUM_SRC*8-1:0] temps;
    logic [7:0]                   demand;
    logic                         any_on;
    modport bank (output enable, output temps, input demand, input any_on);
    modport sel  (input enable, input temps, output demand, output any_on);
endinterface

// ### verilog/fssc_src_select.sv
/*
 * Picks the hottest enabled temperature for one fan output.
 * Assumes temperatures are unsigned codes where higher means hotter.
 */
`timescale 1ns/1ps
module fssc_src_select (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Selector side
    fssc_sel_if.sel   s
);
    typedef struct packed {
        logic [7:0] demand;
        logic       any_on;
    } fssc_sel_state_type;

    fssc_sel_state_type st_r;
    fssc_sel_state_type st_nxt;

    always_comb begin
        st_nxt = '{default: '0};
        for (int i = 0; i < fssc_pkg::NUM_SRC; i++) begin
            if (s.enable[i] && s.temps[i*8 +: 8] >= st_nxt.demand) begin
                st_nxt.demand = s.temps[i*8 +: 8];
                st_nxt.any_on = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= '{default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s.demand = st_r.demand;
    assign s.any_on = st_r.any_on;
endmodule // fssc_src_select

// ### verif/fssc_bank_sva.sv
/*
 * Concurrent checks on the ports of the fan source select register bank.
 * Assumes it is bound to fssc_bank and sees only that module's ports.
 */
`timescale 1ns/1ps
module fssc_bank_sva (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Bus
    input wire logic [9:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [1:0]  avs_response,
    // Observed pins
    input wire logic [3:0]  module_temp_valid,
    input wire logic [2:0]  fan_out_disable,
    input wire logic [3:0]  module_forward_en,
    input wire logic [2:0]  cpu_dual_domain,
    input wire logic [2:0]  cpu_count,
    input wire logic [7:0]  fan1_demand,
    input wire logic        fan1_active,
    input wire logic [7:0]  fan2_demand,
    input wire logic        fan2_active
);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    // The write data is captured because the master releases it after the answer.
    logic [7:0] wdat_r;
    logic       done;
    logic       mapped;
    assign done   = !avs_waitrequest;
    assign mapped = avs_address >= 10'h218 && avs_address <= 10'h238 && avs_address[1:0] == 2'b00;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdat_r <= 8'h00;
        end else if (done && avs_write) begin
            wdat_r <= avs_writedata[7:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_cfg9_wr;
        done && avs_write && avs_byteenable[0] && avs_address == {fssc_pkg::IDX_CFG9, 2'b00};
    endsequence
    sequence s_cpu_wr;
        done && avs_write && avs_byteenable[0] && avs_address == {fssc_pkg::IDX_CPU_CFG, 2'b00};
    endsequence
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    property p_fan_off; s_cfg9_wr |-> ##2 fan_out_disable == wdat_r[2:0]; endproperty
    a_fan_off: assert property (p_fan_off) else $error("fan disable bits differ");
    property p_cpu_cfg;
        s_cpu_wr |-> ##2 (cpu_count == {1'b0, wdat_r[7:6]} + 3'h1
                          && cpu_dual_domain == {wdat_r[3], wdat_r[4], wdat_r[5]});
    endproperty
    a_cpu_cfg: assert property (p_cpu_cfg) else $error("processor config wrong");
    property p_forward; (module_forward_en & ~$past(module_temp_valid)) == 4'h0; endproperty
    a_forward: assert property (p_forward) else $error("forwarding without valid module");
    property p_fan1_off;
        fan_out_disable[0] [*3] |-> fan1_demand == 8'h00 && !fan1_active;
    endproperty
    a_fan1_off: assert property (p_fan1_off) else $error("fan1 driven while off");
    property p_fan2_off;
        fan_out_disable[1] [*3] |-> fan2_demand == 8'h00 && !fan2_active;
    endproperty
    a_fan2_off: assert property (p_fan2_off) else $error("fan2 driven while off");
    property p_one_cycle; $fell(avs_waitrequest) |=> avs_waitrequest; endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("waitrequest low too long");
    property p_answer; $rose(avs_read || avs_write) |-> ##[1:4] !avs_waitrequest; endproperty
    a_answer: assert property (p_answer) else $error("no answer to request");
    property p_no_spurious; !avs_waitrequest |-> avs_read || avs_write; endproperty
    a_no_spurious: assert property (p_no_spurious) else $error("answer without request");
    property p_unmapped;
        done && avs_read && !mapped |-> avs_response == 2'b10 && avs_readdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    property p_mapped;
        done && mapped |-> avs_response == 2'b00 && avs_readdata[31:8] == 24'h0;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access answered wrongly");
endmodule // fssc_bank_sva

bind fssc_bank fssc_bank_sva u_sva (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .module_temp_valid(module_temp_valid),
    .fan_out_disable(fan_out_disable), .module_forward_en(module_forward_en),
    .cpu_dual_domain(cpu_dual_domain), .cpu_count(cpu_count), .fan1_demand(fan1_demand),
    .fan1_active(fan1_active), .fan2_demand(fan2_demand), .fan2_active(fan2_active)
);

// ### verif/fssc_bank_test.sv
/*
 * Self-checking testbench of the fan source select register bank.
 * Assumes the bank answers each bus request within a few cycles.
 */
`timescale 1ns/1ps
module fssc_bank_test;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [9:0]  avs_address = 10'h000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  avs_response;
    // Every temperature is distinct so that the chosen source is identifiable.
    logic [55:0] sensor_temps = 56'h46454443424140;
    logic [63:0] bus_dev_temps = 64'h4e4d4c4b4a494847;
    logic [31:0] written_temps = 32'h5251504f;
    logic [7:0]  stat_in = 8'h00;
    logic [3:0]  module_temp_valid = 4'h0;
    logic [2:0]  fan_out_disable, cpu_dual_domain, cpu_count;
    logic [3:0]  module_forward_en;
    logic [7:0]  supply_rail_high_limit, fan1_demand, fan2_demand;
    logic        fan1_active, fan2_active;
    logic [31:0] rdata;
    logic [1:0]  resp;
    int          n_errors = 0;
    int          checks = 0;
    always #20 clk = ~clk;
    fssc_bank u_dut (
        .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response(avs_response), .sensor_temps(sensor_temps),
        .bus_dev_temps(bus_dev_temps), .written_temps(written_temps),
        .proc_ctrl_temp_over(stat_in[3:0]), .remote_a_over_limit(stat_in[4]),
        .local_over_limit(stat_in[5]), .remote_b_over_limit(stat_in[6]),
        .ext_status_any(stat_in[7]), .module_temp_valid(module_temp_valid),
        .fan_out_disable(fan_out_disable), .module_forward_en(module_forward_en),
        .cpu_dual_domain(cpu_dual_domain), .cpu_count(cpu_count),
        .supply_rail_high_limit(supply_rail_high_limit), .fan1_demand(fan1_demand),
        .fan1_active(fan1_active), .fan2_demand(fan2_demand), .fan2_active(fan2_active)
    );
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task bus(input logic we, input logic [9:0] ad, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= ad;
        avs_writedata <= {24'h0, wd};
        avs_read <= !we;
        avs_write <= we;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        check(32'(n < 50), 32'h1);
        rdata = avs_readdata;
        resp = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task wr(input logic [7:0] idx, input logic [7:0] wd);
        bus(1'b1, {idx, 2'b00}, wd);
    endtask
    task rd(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, {idx, 2'b00}, 8'h00);
        check(rdata, {24'h0, exp});
    endtask
    task test_done;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_regs;
        logic [7:0] rstv [9];
        logic [7:0] wmask [9];
        rstv = '{8'hff, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00};
        wmask = '{8'hff, 8'hf7, 8'hf8, 8'h00, 8'h7f, 8'hff, 8'h0f, 8'h7f, 8'h07};
        check(32'(supply_rail_high_limit), 32'hff);
        for (int k = 0; k < 9; k++) begin
            rd(8'h86 + 8'(k), rstv[k]);
            wr(8'h86 + 8'(k), 8'hff);
            rd(8'h86 + 8'(k), wmask[k]);
            wr(8'h86 + 8'(k), 8'h00);
            rd(8'h86 + 8'(k), 8'h00);
        end
        check(32'(supply_rail_high_limit), 32'h00);
        bus(1'b0, 10'h23c, 8'h00);
        check({30'h0, resp}, 32'h2);
        bus(1'b0, 10'h219, 8'h00);
        check({30'h0, resp}, 32'h2);
        check(rdata, 32'h0);
    endtask
    task t_config;
        logic [7:0] v;
        wr(fssc_pkg::IDX_CFG9, 8'h35);
        module_temp_valid <= 4'hf;
        repeat (3) @(posedge clk);
        check(32'(fan_out_disable), 32'h5);
        check(32'(module_forward_en), 32'h3);
        module_temp_valid <= 4'h6;
        repeat (3) @(posedge clk);
        check(32'(module_forward_en), 32'h2);
        for (int c = 0; c < 4; c++) begin
            v = 8'(c * 64 + (c + 1) * 8);
            wr(fssc_pkg::IDX_CPU_CFG, v);
            rd(fssc_pkg::IDX_CPU_CFG, v);
            repeat (3) @(posedge clk);
            check(32'(cpu_count), 32'(c + 1));
            check(32'(cpu_dual_domain), {29'h0, v[3], v[4], v[5]});
        end
    endtask
    task t_status;
        for (int i = 0; i < 8; i++) begin
            stat_in <= 8'h01 << i;
            repeat (2) @(posedge clk);
            rd(fssc_pkg::IDX_OT_STATUS, 8'h01 << i);
        end
        wr(fssc_pkg::IDX_OT_STATUS, 8'h00);
        rd(fssc_pkg::IDX_OT_STATUS, 8'h80);
        stat_in <= 8'h00;
    endtask
    task t_demand;
        logic [18:0] m;
        wr(fssc_pkg::IDX_CFG9, 8'h00);
        for (int j = 0; j < 19; j++) begin
            m = 19'h1 << j;
            wr(8'h8a, {1'b0, m[6:0]});
            wr(8'h8b, m[14:7]);
            wr(8'h8c, {4'h0, m[18:15]});
            wr(8'h8d, {1'b0, m[6:0]});
            wr(8'h8e, m[14:7]);
            repeat (3) @(posedge clk);
            check(32'(fan1_demand), 32'(8'h40 + j));
            check(32'(fan1_active), 32'h1);
            check(32'(fan2_active), 32'(j < 10));
            if (j < 10) check(32'(fan2_demand), 32'(8'h40 + j));
        end
        wr(8'h8a, 8'h7f);
        wr(8'h8b, 8'hff);
        repeat (3) @(posedge clk);
        check(32'(fan1_demand), 32'h52);
        sensor_temps[7:0] <= 8'h90;
        repeat (3) @(posedge clk);
        check(32'(fan1_demand), 32'h90);
        wr(8'h8d, 8'h7f);
        repeat (3) @(posedge clk);
        check(32'(fan2_active), 32'h1);
        check(32'(fan2_demand), 32'h90);
        wr(fssc_pkg::IDX_CFG9, 8'h03);
        repeat (4) @(posedge clk);
        check({fan1_demand, 7'h0, fan1_active, 7'h0, fan2_active}, 32'h0);
        check(32'(fan2_demand), 32'h0);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("ERROR %0t: watchdog expired", $time);
        test_done;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_config;
        t_status;
        t_demand;
        test_done;
    end
endmodule // fssc_bank_test
